// *** src/tti_map.svh ***
`ifndef TTI_MAP_SVH
`define TTI_MAP_SVH

// instruction codes, ten bits each
`define TTI_OP_LOAD_T2_LOW 10'h231
`define TTI_OP_LOAD_HIGH 10'h294
`define TTI_OP_COPY_LOW_T2 10'h295
`define TTI_OP_READ_T1 10'h270
`define TTI_OP_READ_T2 10'h271

// nibble field positions inside an 8-bit timer word
`define TTI_HI_MSB 7
`define TTI_HI_LSB 4
`define TTI_LO_MSB 3
`define TTI_LO_LSB 0

// reset values
`define TTI_RELOAD_RST 8'h00
`define TTI_NIB_RST 4'h0

// every instruction of this group takes one cycle
`define TTI_EXEC_CYCLES 1

`endif

// *** src/tti_pkg.sv ***
package tti_pkg;

  // which member of the group is executing
  typedef enum logic [2:0] {
    TTI_OP_NONE,
    TTI_OP_LOAD_T2_LOW,
    TTI_OP_LOAD_HIGH,
    TTI_OP_COPY_LOW_T2,
    TTI_OP_READ_T1,
    TTI_OP_READ_T2
  } tti_op_e;

  // upper and lower nibble travelling together
  typedef struct packed {
    logic [3:0] hi;
    logic [3:0] lo;
  } tti_pair_s;

endpackage : tti_pkg

// *** src/tti_reload_store.sv ***
`timescale 1ns/1ps
`include "tti_map.svh"

// low and high reload words of timer 2, read data straight from flops
module tti_reload_store
  import tti_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic low_we_i,
  input wire logic high_we_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] low_q_o,
  output logic [WIDTH-1:0] high_q_o
);

  // low reload word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      low_q_o <= WIDTH'(`TTI_RELOAD_RST);
    end else if (low_we_i) begin
      low_q_o <= wdata_i;
    end
  end

  // high reload word
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      high_q_o <= WIDTH'(`TTI_RELOAD_RST);
    end else if (high_we_i) begin
      high_q_o <= wdata_i;
    end
  end

endmodule : tti_reload_store

// *** src/tti_top.sv ***
`timescale 1ns/1ps
`include "tti_map.svh"

module tti_top
  import tti_pkg::*;
#(
  parameter int TW = 8
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic INSTR_VALID_I,
  input wire logic [9:0] INSTR_CODE_I,
  input wire logic [3:0] ACC_I,
  input wire logic [3:0] B_I,
  input wire logic [TW-1:0] T1_COUNT_I,
  input wire logic [TW-1:0] T2_COUNT_I,
  output logic AB_WE_O,
  output logic [3:0] ACC_O,
  output logic [3:0] B_O,
  output logic T2_LOAD_O,
  output logic [TW-1:0] T2_DATA_O,
  output logic [TW-1:0] T2_LOW_RELOAD_O,
  output logic [TW-1:0] T2_HIGH_RELOAD_O
);

  // shared decode; the cpu owns all other codes so anything else is no-op
  function automatic tti_op_e decode_op(input logic valid, input logic [9:0] code);
    tti_op_e op;
    op = TTI_OP_NONE;
    if (valid) begin
      case (code)
        `TTI_OP_LOAD_T2_LOW: op = TTI_OP_LOAD_T2_LOW;
        `TTI_OP_LOAD_HIGH: op = TTI_OP_LOAD_HIGH;
        `TTI_OP_COPY_LOW_T2: op = TTI_OP_COPY_LOW_T2;
        `TTI_OP_READ_T1: op = TTI_OP_READ_T1;
        `TTI_OP_READ_T2: op = TTI_OP_READ_T2;
        default: op = TTI_OP_NONE;
      endcase
    end
    return op;
  endfunction : decode_op

  tti_op_e op;
  tti_pair_s ab_pair;
  tti_pair_s t1_pair;
  tti_pair_s t2_pair;
  logic [TW-1:0] low_q;
  logic [TW-1:0] high_q;
  logic low_we;
  logic high_we;

  // one sample of each counter per cycle, so both nibbles share it
  assign op = decode_op(INSTR_VALID_I, INSTR_CODE_I);
  assign ab_pair = '{hi: B_I, lo: ACC_I};
  assign t1_pair = T1_COUNT_I[`TTI_HI_MSB:`TTI_LO_LSB];
  assign t2_pair = T2_COUNT_I[`TTI_HI_MSB:`TTI_LO_LSB];
  assign low_we = (op == TTI_OP_LOAD_T2_LOW);
  assign high_we = (op == TTI_OP_LOAD_HIGH);

  // reload words; both take B as upper nibble and A as lower
  tti_reload_store #(
    .WIDTH(TW)
  ) u_store (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .low_we_i(low_we),
    .high_we_i(high_we),
    .wdata_i(TW'(ab_pair)),
    .low_q_o(low_q),
    .high_q_o(high_q)
  );

  assign T2_LOW_RELOAD_O = low_q;
  assign T2_HIGH_RELOAD_O = high_q;

  // accumulator pair write-back from the timer reads
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AB_WE_O <= 1'b0;
      ACC_O <= `TTI_NIB_RST;
      B_O <= `TTI_NIB_RST;
    end else begin
      AB_WE_O <= 1'b0;
      case (op)
        TTI_OP_READ_T1: begin
          AB_WE_O <= 1'b1;
          B_O <= t1_pair.hi;
          ACC_O <= t1_pair.lo;
        end
        TTI_OP_READ_T2: begin
          AB_WE_O <= 1'b1;
          B_O <= t2_pair.hi;
          ACC_O <= t2_pair.lo;
        end
        default: begin
          AB_WE_O <= 1'b0;
        end
      endcase
    end
  end

  // timer 2 counter load; the copy reads the stored low word, which
  // already holds a load from the previous cycle
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      T2_LOAD_O <= 1'b0;
      T2_DATA_O <= TW'(`TTI_RELOAD_RST);
    end else begin
      T2_LOAD_O <= 1'b0;
      case (op)
        TTI_OP_LOAD_T2_LOW: begin
          T2_LOAD_O <= 1'b1;
          T2_DATA_O <= TW'(ab_pair);
        end
        TTI_OP_COPY_LOW_T2: begin
          T2_LOAD_O <= 1'b1;
          T2_DATA_O <= low_q;
        end
        default: begin
          T2_LOAD_O <= 1'b0;
        end
      endcase
    end
  end

  // assertions
  sequence s_read_t1;
    decode_op(INSTR_VALID_I, INSTR_CODE_I) == TTI_OP_READ_T1;
  endsequence

  sequence s_read_t2;
    decode_op(INSTR_VALID_I, INSTR_CODE_I) == TTI_OP_READ_T2;
  endsequence

  // load and copy seen straight from the pins, not through decode_op
  sequence s_load_low;
    INSTR_VALID_I && INSTR_CODE_I == `TTI_OP_LOAD_T2_LOW;
  endsequence

  sequence s_copy;
    INSTR_VALID_I && INSTR_CODE_I == `TTI_OP_COPY_LOW_T2;
  endsequence

  a_load_t2_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (op == TTI_OP_LOAD_T2_LOW) |=> T2_LOAD_O && T2_DATA_O == {$past(B_I), $past(ACC_I)}
      && T2_LOW_RELOAD_O == T2_DATA_O)
    else $error("timer2 and low reload not loaded from B and A");

  a_high_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (INSTR_VALID_I && INSTR_CODE_I == 10'h294)
      |=> T2_HIGH_RELOAD_O == {$past(B_I), $past(ACC_I)} && !T2_LOAD_O)
    else $error("high reload not loaded from B and A");

  a_high_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (op != TTI_OP_LOAD_HIGH) |=> $stable(T2_HIGH_RELOAD_O))
    else $error("high reload changed without its load");

  a_copy_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (op == TTI_OP_COPY_LOW_T2) |=> T2_LOAD_O && T2_DATA_O == $past(T2_LOW_RELOAD_O))
    else $error("copy did not move low reload into timer2");

  a_t1_upper: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_read_t1 |=> AB_WE_O && B_O == $past(T1_COUNT_I[7:4]))
    else $error("timer1 upper nibble not in B");

  a_t1_lower: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_read_t1 |=> ACC_O == $past(T1_COUNT_I[3:0]) && !T2_LOAD_O)
    else $error("timer1 lower nibble not in A");

  a_t2_read: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_read_t2 |=> AB_WE_O && B_O == $past(T2_COUNT_I[7:4]) && ACC_O == $past(T2_COUNT_I[3:0]))
    else $error("timer2 read nibbles wrong");

  a_pair_same: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (s_read_t1 or s_read_t2) |=> {B_O, ACC_O} == $past(op == TTI_OP_READ_T1 ? T1_COUNT_I
      : T2_COUNT_I))
    else $error("read nibbles from different samples");

  a_we_only_reads: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    AB_WE_O |-> $past(op == TTI_OP_READ_T1 || op == TTI_OP_READ_T2))
    else $error("accumulator write without a timer read");

  a_low_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (op != TTI_OP_LOAD_T2_LOW) |=> $stable(T2_LOW_RELOAD_O))
    else $error("low reload changed without its load");

  a_load_only_ops: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    T2_LOAD_O |-> $past(op == TTI_OP_LOAD_T2_LOW || op == TTI_OP_COPY_LOW_T2))
    else $error("timer2 load without a load or copy");

  // the hazard: a copy right behind a load must not see the old low word
  a_copy_fresh: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_load_low ##1 s_copy |=> T2_LOAD_O && T2_DATA_O == {$past(B_I, 2), $past(ACC_I, 2)})
    else $error("copy after load used a stale low word");

  a_copy_no_store: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    s_copy |=> $stable(T2_LOW_RELOAD_O) && $stable(T2_HIGH_RELOAD_O) && !AB_WE_O)
    else $error("copy disturbed a reload word");

  a_read_no_store: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    (s_read_t1 or s_read_t2) |=> $stable(T2_LOW_RELOAD_O) && $stable(T2_HIGH_RELOAD_O))
    else $error("timer read disturbed a reload word");

  // the cycle right after reset is skipped; outputs jump to zero there
  a_data_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $past(RST_N_I) && !T2_LOAD_O |-> $stable(T2_DATA_O))
    else $error("timer2 data moved without a load");

  a_pair_hold: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $past(RST_N_I) && !AB_WE_O |-> $stable({B_O, ACC_O}))
    else $error("accumulator pair moved without a write");

  a_pulse_apart: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !(AB_WE_O && T2_LOAD_O))
    else $error("accumulator write and timer2 load together");

endmodule : tti_top

// *** tb/tti_timer_model.sv ***
`timescale 1ns/1ps
// far-side counters; they keep moving so a read is judged on one sample
module tti_timer_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  output logic [7:0] t1_o,
  output logic [7:0] t2_o
);
  // timer 1 counts down every cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) t1_o <= 8'h5a;
    else t1_o <= t1_o - 8'h01;
  end
  // timer 2 steps up unless the block loads it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) t2_o <= 8'hc3;
    else if (load_i) t2_o <= data_i;
    else t2_o <= t2_o + 8'h07;
  end
endmodule : tti_timer_model

// *** tb/tti_top_tb.sv ***
`timescale 1ns/1ps
module tti_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic [9:0] code = 10'h000;
  logic [3:0] acc = 4'h0;
  logic [3:0] b = 4'h0;
  logic [7:0] t1, t2, s1, s2, d_o, lo_o, hi_o;
  logic we, ld;
  logic [3:0] acc_o, b_o;
  int miscompares = 0;
  int checks_done = 0;
  // 50 ns period
  always #25 clk = ~clk;
  tti_timer_model u_tmr (.clk_i(clk), .rst_n_i(rst_n), .load_i(ld), .data_i(d_o),
    .t1_o(t1), .t2_o(t2));
  tti_top u_dut (.CLK_I(clk), .RST_N_I(rst_n), .INSTR_VALID_I(vld), .INSTR_CODE_I(code),
    .ACC_I(acc), .B_I(b), .T1_COUNT_I(t1), .T2_COUNT_I(t2), .AB_WE_O(we), .ACC_O(acc_o),
    .B_O(b_o), .T2_LOAD_O(ld), .T2_DATA_O(d_o), .T2_LOW_RELOAD_O(lo_o),
    .T2_HIGH_RELOAD_O(hi_o));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // called at an edge; returns at the taking edge, counters sampled at the negedge before it
  task automatic exec(input logic [9:0] c, input logic [3:0] a, input logic [3:0] bb,
                      input bit keep);
    vld <= 1'b1;
    code <= c;
    acc <= a;
    b <= bb;
    // counters only move on the rising edge, so this is what the edge takes
    @(negedge clk);
    s1 = t1;
    s2 = t2;
    @(posedge clk);
    if (!keep) vld <= 1'b0;
  endtask : exec
  task automatic t_load;
    @(posedge clk);
    exec(10'h231, 4'hc, 4'h3, 1'b0);
    @(negedge clk);
    check("load pulse", 8'(ld), 8'h01);
    check("load data", d_o, 8'h3c);
    check("low reload", lo_o, 8'h3c);
    check("ab write", 8'(we), 8'h00);
  endtask : t_load
  task automatic t_high;
    @(posedge clk);
    exec(10'h294, 4'h5, 4'ha, 1'b0);
    @(negedge clk);
    check("high reload", hi_o, 8'ha5);
    check("no load", 8'(ld), 8'h00);
    check("low kept", lo_o, 8'h3c);
  endtask : t_high
  // copy straight after a low load must use the fresh low word
  task automatic t_copy;
    @(posedge clk);
    exec(10'h231, 4'h7, 4'he, 1'b1);
    exec(10'h295, 4'h0, 4'h0, 1'b0);
    @(negedge clk);
    check("copy pulse", 8'(ld), 8'h01);
    check("copy data", d_o, 8'he7);
    @(negedge clk);
    check("timer2 loaded", t2, 8'he7);
    check("pulse ends", 8'(ld), 8'h00);
  endtask : t_copy
  task automatic t_read(input logic [9:0] c, input logic [7:0] hi_keep);
    logic [7:0] s;
    @(posedge clk);
    exec(c, 4'h9, 4'h6, 1'b0);
    s = c[0] ? s2 : s1;
    @(negedge clk);
    check("ab write", 8'(we), 8'h01);
    check("b nibble", 8'(b_o), 8'(s[7:4]));
    check("acc nibble", 8'(acc_o), 8'(s[3:0]));
    check("high kept", hi_o, hi_keep);
  endtask : t_read
  // unused code, then a read code with valid low: nothing may move
  task automatic t_unused;
    logic [7:0] d_was;
    logic [3:0] b_was;
    logic [3:0] a_was;
    @(negedge clk);
    d_was = d_o;
    b_was = b_o;
    a_was = acc_o;
    @(posedge clk);
    exec(10'h3ff, 4'h9, 4'h6, 1'b0);
    code <= 10'h270;
    @(negedge clk);
    check("ab write", 8'(we), 8'h00);
    check("no load", 8'(ld), 8'h00);
    @(posedge clk);
    @(negedge clk);
    check("ab write idle", 8'(we), 8'h00);
    check("b held", 8'(b_o), 8'(b_was));
    check("acc held", 8'(acc_o), 8'(a_was));
    check("data held", d_o, d_was);
    check("high kept", hi_o, 8'ha5);
    check("low kept", lo_o, 8'he7);
  endtask : t_unused
  // reset in mid-run clears every output, and pulses and reloads stay clear at the first edge after
  task automatic t_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("reset pair", {b_o, acc_o}, 8'h00);
    check("reset data", d_o | lo_o | hi_o, 8'h00);
    check("reset pulses", {6'h00, we, ld}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("pulses after release", {6'h00, we, ld}, 8'h00);
    check("reloads after release", lo_o | hi_o, 8'h00);
  endtask : t_reset
  task automatic conclude;
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (16) @(posedge clk);
    check("reset reload", lo_o | hi_o, 8'h00);
    rst_n <= 1'b1;
    @(posedge clk);
    t_load();
    t_high();
    t_copy();
    t_read(10'h270, 8'ha5);
    t_read(10'h271, 8'ha5);
    // unused code and an idle valid leave everything alone
    t_unused();
    // reset again mid-run, then read straight after release
    t_reset();
    t_read(10'h270, 8'h00);
    conclude();
  end
endmodule : tti_top_tb
